// [led_cfg_pkg.sv]
// Constants, field layout and types of the LED driver configuration bank
package led_cfg_pkg;
  // ----------------------------------------
  // Bus and register map
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam logic [5:0] IDX_SPREAD_SLOPE_DITHER = 6'h04;
  localparam logic [5:0] IDX_DETECT_SHORT_MASK = 6'h06;
  localparam logic [5:0] IDX_SLOPE_STATUS = 6'h20;
  localparam logic [15:0] RST_SPREAD_SLOPE_DITHER = 16'h08a3;
  localparam logic [15:0] RST_DETECT_SHORT_MASK = 16'h0100;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int POS_PSEUDO_EN = 14;
  localparam int POS_MOD_RATE = 12;
  localparam int POS_SPREAD_RANGE = 10;
  localparam int POS_BRT_SRC = 8;
  localparam int POS_SLOPE_SEL = 5;
  localparam int POS_DITHER = 2;
  localparam int POS_SMOOTH_EN = 1;
  localparam int POS_GND_DETECT = 8;
  localparam int POS_NORMAL_OP = 6;
  localparam int POS_SHORT_MASK = 0;
  localparam int NUM_STRINGS = 6;
  // ----------------------------------------
  // Codes
  // ----------------------------------------
  localparam logic [1:0] SRC_PWM_PIN = 2'h0;
  localparam logic [1:0] SRC_BRT_REG = 2'h2;
  localparam logic [2:0] SLOPE_OFF = 3'h0;
  localparam logic [2:0] DITHER_MAX = 3'h4;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;
  localparam int STEP_SHIFT = 16;
  localparam int SMOOTH_SHIFT = 3;
  localparam int ADV_STRETCH_SHIFT = 1;
  // Slope duration in ms for each code
  function automatic int unsigned slope_ms(input logic [2:0] code);
    case (code)
      3'h1: slope_ms = 1;
      3'h2: slope_ms = 2;
      3'h3: slope_ms = 50;
      3'h4: slope_ms = 100;
      3'h5: slope_ms = 200;
      3'h6: slope_ms = 300;
      3'h7: slope_ms = 500;
      default: slope_ms = 0;
    endcase
  endfunction : slope_ms
  typedef enum logic [1:0] {S_IDLE, S_LINEAR, S_SMOOTH} slope_state_e;
endpackage : led_cfg_pkg

// [cfg_access_if.sv]
// Register access strobes between bus front end and register bank
interface cfg_access_if;
  import led_cfg_pkg::*;
  logic wr_en;
  logic [5:0] wr_idx;
  logic [REG_W-1:0] wr_data;
  logic [1:0] wr_strb;
  logic wr_hit;
  logic [5:0] rd_idx;
  logic [REG_W-1:0] rd_data;
  logic rd_hit;
  modport front (output wr_en, wr_idx, wr_data, wr_strb, rd_idx, input wr_hit, rd_data, rd_hit);
  modport bank (input wr_en, wr_idx, wr_data, wr_strb, rd_idx, output wr_hit, rd_data, rd_hit);
endinterface : cfg_access_if

// [cfg_axil_slave.sv]
// AXI4-Lite slave front end producing register access strobes
module cfg_axil_slave
  import led_cfg_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [DATA_W-1:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  cfg_access_if.front acc
);
  import led_cfg_pkg::*;
  logic [5:0] aw_idx_r;
  logic [REG_W-1:0] wdata_r;
  logic [1:0] wstrb_r;
  logic [5:0] ar_idx_r;
  logic ar_held_r;
  logic do_write;

  // ----------------------------------------
  // Write channels
  // ----------------------------------------
  assign do_write = !o_awready && !o_wready && !o_bvalid;
  assign acc.wr_en = do_write;
  assign acc.wr_idx = aw_idx_r;
  assign acc.wr_data = wdata_r;
  assign acc.wr_strb = wstrb_r;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      o_bvalid <= 1'b0;
      o_bresp <= RESP_OKAY;
      aw_idx_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else begin
      if (o_awready && i_awvalid) begin
        o_awready <= 1'b0;
        aw_idx_r <= i_awaddr[7:2];
      end
      if (o_wready && i_wvalid) begin
        o_wready <= 1'b0;
        wdata_r <= i_wdata[REG_W-1:0];
        wstrb_r <= i_wstrb[1:0];
      end
      if (do_write) begin
        o_bvalid <= 1'b1;
        o_bresp <= acc.wr_hit ? RESP_OKAY : RESP_DECERR;
      end
      if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Read channels
  // ----------------------------------------
  assign acc.rd_idx = ar_idx_r;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_arready <= 1'b1;
      ar_held_r <= 1'b0;
      ar_idx_r <= '0;
      o_rvalid <= 1'b0;
      o_rdata <= '0;
      o_rresp <= RESP_OKAY;
    end else begin
      if (o_arready && i_arvalid) begin
        o_arready <= 1'b0;
        ar_held_r <= 1'b1;
        ar_idx_r <= i_araddr[7:2];
      end
      if (ar_held_r) begin
        ar_held_r <= 1'b0;
        o_rvalid <= 1'b1;
        o_rdata <= {{(DATA_W-REG_W){1'b0}}, acc.rd_data};
        o_rresp <= acc.rd_hit ? RESP_OKAY : RESP_DECERR;
      end
      if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
        o_arready <= 1'b1;
      end
    end
  end
endmodule : cfg_axil_slave

// [brightness_slope.sv]
// Brightness transition engine: linear or smoothed approach to target
module brightness_slope
  import led_cfg_pkg::*;
#(
  parameter int unsigned CYCLES_PER_MS = CYC_PER_MS
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [REG_W-1:0] i_target,
  input wire logic [2:0] i_slope_sel,
  input wire logic i_smooth_en,
  output logic [REG_W-1:0] o_level,
  output logic o_busy
);
  import led_cfg_pkg::*;
  slope_state_e state_r;
  logic [31:0] tick_cnt_r;
  logic [31:0] interval;
  logic [63:0] dur_cyc;
  logic [REG_W-1:0] diff;
  logic ease;
  logic up;

  // Full-scale transition takes the selected duration; smoothing stretches it
  always_comb begin
    dur_cyc = 64'(slope_ms(i_slope_sel)) * 64'(CYCLES_PER_MS);
    interval = 32'(dur_cyc >> STEP_SHIFT);
    if (interval == 32'h0) begin
      interval = 32'h1;
    end
    up = i_target > o_level;
    diff = up ? i_target - o_level : o_level - i_target;
    ease = diff < (REG_W'(1) << SMOOTH_SHIFT);
    if (state_r == S_SMOOTH) begin
      interval = interval << ADV_STRETCH_SHIFT; // R06
      if (ease) begin
        interval = interval << ADV_STRETCH_SHIFT; // R06
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r <= S_IDLE;
      tick_cnt_r <= '0;
      o_level <= '0;
      o_busy <= 1'b0;
    end else begin
      case (state_r)
        S_IDLE: begin
          tick_cnt_r <= '0;
          if (i_slope_sel == SLOPE_OFF) begin
            o_level <= i_target; // R05
          end else if (diff != '0) begin
            state_r <= i_smooth_en ? S_SMOOTH : S_LINEAR; // R09
            o_busy <= 1'b1;
          end
        end
        S_LINEAR, S_SMOOTH: begin
          if (i_slope_sel == SLOPE_OFF || diff == '0) begin
            o_level <= i_target;
            o_busy <= 1'b0;
            state_r <= S_IDLE;
          end else if (tick_cnt_r + 32'h1 >= interval) begin
            tick_cnt_r <= '0;
            o_level <= up ? o_level + 16'h1 : o_level - 16'h1; // R05 R06
          end else begin
            tick_cnt_r <= tick_cnt_r + 32'h1;
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end
endmodule : brightness_slope

// [led_cfg_regs.sv]
// Top: user configuration registers of the backlight LED driver
// Notes on behaviour
// R01: bit 14 of config word one enables pseudo-random boost spreading; default off.
// R02: bits 13-12 pick modulation rate 200/500/800/1200 Hz; default code 0.
// R03: bits 11-10 pick spreading range 3.3/4.3/5.3/7.2 percent; resets to code 2.
// R04: bits 9-8 pick brightness source, pin for 0, register for 2; 1,3 reserved.
// R05: bits 7-5 set slope duration, 0 off, 1..7 = 1..500 ms; reset 5.
// R06: smoothed sloping lengthens transitions and smooths the brightness change.
// R07: software uses 1 and 2 ms durations only with linear sloping.
// R08: bits 4-2 select dither depth, 0 off, 1 to 4 bits; reset 0.
// R09: bit 1 selects linear when clear, smoothed when set; smoothed after reset.
// R10: bit 8 of word two enables ground-short detection; default enabled.
// R11: software always writes zero into bits 7-6 of word two.
// R12: bits 5-0 of word two mask internal-short fault of strings 6 to 1.
// R13: word two sits at offset 0x06, resetting to 0x100.
// R14: fields hold last written value until reset; reads return it, reserved bits too.
module led_cfg_regs
  import led_cfg_pkg::*;
#(
  parameter int unsigned CYCLES_PER_MS = CYC_PER_MS
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [led_cfg_pkg::ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [led_cfg_pkg::DATA_W-1:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [led_cfg_pkg::ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [led_cfg_pkg::DATA_W-1:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic [led_cfg_pkg::REG_W-1:0] i_pwm_duty,
  input wire logic [led_cfg_pkg::REG_W-1:0] i_brightness_register_value,
  input wire logic [led_cfg_pkg::NUM_STRINGS-1:0] i_string_short_raw,
  output logic o_boost_oscillator_pseudo_en,
  output logic [1:0] o_spread_modulation_rate,
  output logic [1:0] o_spread_range,
  output logic [2:0] o_dither_depth,
  output logic o_ground_short_detect_enable,
  output logic [led_cfg_pkg::NUM_STRINGS-1:0] o_string_short_fault,
  output logic [led_cfg_pkg::REG_W-1:0] o_brightness_level,
  output logic o_slope_busy
);
  import led_cfg_pkg::*;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [REG_W-1:0] spread_slope_dither_config_r;
  logic [REG_W-1:0] detect_and_short_mask_config_r;
  logic [REG_W-1:0] target_r;
  logic [REG_W-1:0] slope_level;
  logic slope_busy;

  cfg_access_if acc ();

  // Index decoding and byte merging used by the write paths
  function automatic logic idx_writable(input logic [5:0] idx);
    idx_writable = (idx == IDX_SPREAD_SLOPE_DITHER) || (idx == IDX_DETECT_SHORT_MASK);
  endfunction : idx_writable

  function automatic logic [REG_W-1:0] merge_bytes(input logic [REG_W-1:0] old_v,
                                                   input logic [REG_W-1:0] new_v,
                                                   input logic [1:0] strb);
    merge_bytes = old_v;
    if (strb[0]) begin
      merge_bytes[7:0] = new_v[7:0];
    end
    if (strb[1]) begin
      merge_bytes[15:8] = new_v[15:8];
    end
  endfunction : merge_bytes

  // ----------------------------------------
  // Bus front end
  // ----------------------------------------
  cfg_axil_slave u_axil (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_awaddr(i_awaddr),
    .i_awvalid(i_awvalid),
    .o_awready(o_awready),
    .i_wdata(i_wdata),
    .i_wstrb(i_wstrb),
    .i_wvalid(i_wvalid),
    .o_wready(o_wready),
    .o_bresp(o_bresp),
    .o_bvalid(o_bvalid),
    .i_bready(i_bready),
    .i_araddr(i_araddr),
    .i_arvalid(i_arvalid),
    .o_arready(o_arready),
    .o_rdata(o_rdata),
    .o_rresp(o_rresp),
    .o_rvalid(o_rvalid),
    .i_rready(i_rready),
    .acc(acc.front)
  );

  assign acc.wr_hit = idx_writable(acc.wr_idx);

  // ----------------------------------------
  // Configuration word one
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      spread_slope_dither_config_r <= RST_SPREAD_SLOPE_DITHER; // R03
    end else if (acc.wr_en && acc.wr_idx == IDX_SPREAD_SLOPE_DITHER) begin
      spread_slope_dither_config_r <= merge_bytes(spread_slope_dither_config_r, acc.wr_data,
                                                  acc.wr_strb); // R14
    end
  end

  // ----------------------------------------
  // Configuration word two
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      detect_and_short_mask_config_r <= RST_DETECT_SHORT_MASK; // R13
    end else if (acc.wr_en && acc.wr_idx == IDX_DETECT_SHORT_MASK) begin
      detect_and_short_mask_config_r <= merge_bytes(detect_and_short_mask_config_r, acc.wr_data,
                                                    acc.wr_strb); // R14
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_comb begin
    acc.rd_hit = 1'b1;
    case (acc.rd_idx)
      IDX_SPREAD_SLOPE_DITHER: acc.rd_data = spread_slope_dither_config_r; // R14
      IDX_DETECT_SHORT_MASK: acc.rd_data = detect_and_short_mask_config_r; // R13
      IDX_SLOPE_STATUS: acc.rd_data = slope_level;
      default: begin
        acc.rd_data = '0;
        acc.rd_hit = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // Boost spreading controls
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_boost_oscillator_pseudo_en <= 1'b0;
      o_spread_modulation_rate <= '0;
      o_spread_range <= '0;
    end else begin
      o_boost_oscillator_pseudo_en <= spread_slope_dither_config_r[POS_PSEUDO_EN]; // R01
      o_spread_modulation_rate <= spread_slope_dither_config_r[POS_MOD_RATE +: 2]; // R02
      o_spread_range <= spread_slope_dither_config_r[POS_SPREAD_RANGE +: 2]; // R03
    end
  end

  // ----------------------------------------
  // Dither depth
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_dither_depth <= '0;
    end else if (spread_slope_dither_config_r[POS_DITHER +: 3] > DITHER_MAX) begin
      o_dither_depth <= DITHER_MAX; // R08
    end else begin
      o_dither_depth <= spread_slope_dither_config_r[POS_DITHER +: 3]; // R08
    end
  end

  // ----------------------------------------
  // Fault detection controls
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ground_short_detect_enable <= 1'b0;
    end else begin
      o_ground_short_detect_enable <= detect_and_short_mask_config_r[POS_GND_DETECT]; // R10
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_STRINGS; g++) begin : g_mask
      always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
          o_string_short_fault[g] <= 1'b0;
        end else begin
          o_string_short_fault[g] <= i_string_short_raw[g] &
                                     !detect_and_short_mask_config_r[POS_SHORT_MASK + g]; // R12
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Brightness source
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      target_r <= '0;
    end else begin
      case (spread_slope_dither_config_r[POS_BRT_SRC +: 2])
        SRC_PWM_PIN: target_r <= i_pwm_duty; // R04
        SRC_BRT_REG: target_r <= i_brightness_register_value; // R04
        default: target_r <= target_r;
      endcase
    end
  end

  // ----------------------------------------
  // Brightness transition
  // ----------------------------------------
  brightness_slope #(
    .CYCLES_PER_MS(CYCLES_PER_MS)
  ) u_slope (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_target(target_r),
    .i_slope_sel(spread_slope_dither_config_r[POS_SLOPE_SEL +: 3]),
    .i_smooth_en(spread_slope_dither_config_r[POS_SMOOTH_EN]),
    .o_level(slope_level),
    .o_busy(slope_busy)
  );

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_brightness_level <= '0;
      o_slope_busy <= 1'b0;
    end else begin
      o_brightness_level <= slope_level; // R06
      o_slope_busy <= slope_busy;
    end
  end
endmodule : led_cfg_regs

// [led_cfg_regs_props.sv]
// Concurrent checks on the configuration bank ports
module led_cfg_regs_props
  import led_cfg_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [led_cfg_pkg::ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic [1:0] o_bresp,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [led_cfg_pkg::DATA_W-1:0] o_rdata,
  input wire logic [1:0] o_rresp,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire logic [5:0] i_string_short_raw,
  input wire logic o_boost_oscillator_pseudo_en,
  input wire logic [1:0] o_spread_range,
  input wire logic [2:0] o_dither_depth,
  input wire logic o_ground_short_detect_enable,
  input wire logic [5:0] o_string_short_fault
);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  reset_values_a: assert property ($fell(i_rst) |=>
    o_spread_range == 2'h2 && o_ground_short_detect_enable && !o_boost_oscillator_pseudo_en && o_dither_depth == 3'h0)
    else $error("config outputs wrong after reset");
  dither_clamp_a: assert property (o_dither_depth <= DITHER_MAX)
    else $error("dither depth above four bits");
  short_mask_a: assert property ((o_string_short_fault & ~$past(i_string_short_raw)) == 6'h00)
    else $error("short fault without raw fault");
  write_answer_a: assert property ((i_awvalid && o_awready && i_wvalid && o_wready) |=> !o_bvalid ##1 o_bvalid)
    else $error("write response late");
  write_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped");
  write_refuse_a: assert property ((i_awvalid && o_awready && i_wvalid && o_wready && i_awaddr == 8'h80)
    |=> !o_bvalid ##1 (o_bvalid && o_bresp == RESP_DECERR)) else $error("read-only write not refused");
  read_answer_a: assert property ((i_arvalid && o_arready) |=> !o_rvalid ##1 o_rvalid)
    else $error("read data not two cycles after address");
  read_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata) && $stable(o_rresp))
    else $error("read data changed while waiting");
  read_busy_a: assert property (o_rvalid |-> !o_arready && o_rdata[31:16] == 16'h0000)
    else $error("read channel state wrong");
endmodule : led_cfg_regs_props

bind led_cfg_regs led_cfg_regs_props u_props (.i_ref_clk, .i_rst, .i_awaddr, .i_awvalid, .o_awready, .i_wvalid,
  .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready,
  .i_string_short_raw, .o_boost_oscillator_pseudo_en, .o_spread_range, .o_dither_depth,
  .o_ground_short_detect_enable, .o_string_short_fault);

// [tb_top.sv]
// Self-checking bench for the configuration bank
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import led_cfg_pkg::*;
  typedef struct {logic [7:0] a; logic [15:0] d; logic [1:0] s;} row_s;
  logic i_ref_clk, i_rst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic [7:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata, o_rdata, rd;
  logic [3:0] i_wstrb;
  logic [15:0] i_pwm_duty, i_brightness_register_value, o_brightness_level, w1, w2;
  logic [5:0] i_string_short_raw, o_string_short_fault;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_slope_busy;
  logic o_boost_oscillator_pseudo_en, o_ground_short_detect_enable;
  logic [1:0] o_bresp, o_rresp, o_spread_modulation_rate, o_spread_range, resp;
  logic [2:0] o_dither_depth;
  int err_count = 0;
  int checked = 0;
  int cyc = 0;
  int busy = 0;
  int lin;
  row_s rows[9] = '{'{8'h10, 16'hfeff, 2'h3}, '{8'h10, 16'h1234, 2'h1}, '{8'h10, 16'h5455, 2'h3},
    '{8'h10, 16'h2a0c, 2'h3}, '{8'h18, 16'h013f, 2'h3}, '{8'h18, 16'h0015, 2'h2}, '{8'h18, 16'h012a, 2'h3},
    '{8'h80, 16'h1111, 2'h3}, '{8'h40, 16'h0001, 2'h3}};

  led_cfg_regs #(.CYCLES_PER_MS(16)) u_dut (.i_ref_clk, .i_rst, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
    .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata,
    .o_rresp, .o_rvalid, .i_rready, .i_pwm_duty, .i_brightness_register_value, .i_string_short_raw,
    .o_boost_oscillator_pseudo_en, .o_spread_modulation_rate, .o_spread_range, .o_dither_depth,
    .o_ground_short_detect_enable, .o_string_short_fault, .o_brightness_level, .o_slope_busy);

  // ----------------------------------------
  // Clock, watchdog, helpers
  // ----------------------------------------
  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) begin
    cyc++;
    if (o_slope_busy === 1'b1) busy++;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end
  task automatic conclude;
    if (err_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic axr(input logic [7:0] a);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    do begin
      @(posedge i_ref_clk);
      if (o_arready) i_arvalid <= 1'b0;
      if (o_rvalid) i_rready <= 1'b1;
    end while (!(o_rvalid && i_rready));
    rd = o_rdata;
    resp = o_rresp;
    i_rready <= 1'b0;
  endtask : axr
  task automatic chk_outs;
    repeat (3) @(posedge i_ref_clk);
    cmp(32'(o_boost_oscillator_pseudo_en), 32'(w1[14]));
    cmp(32'(o_spread_modulation_rate), 32'(w1[13:12]));
    cmp(32'(o_spread_range), 32'(w1[11:10]));
    cmp(32'(o_dither_depth), 32'((w1[4:2] > 3'h4) ? 3'h4 : w1[4:2]));
    cmp(32'(o_ground_short_detect_enable), 32'(w2[8]));
    cmp(32'(o_string_short_fault), 32'(i_string_short_raw & ~w2[5:0]));
    axr(8'h10);
    cmp(rd, {16'h0000, w1});
    axr(8'h18);
    cmp(rd, {16'h0000, w2});
  endtask : chk_outs
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] s);
    logic [15:0] m;
    i_awaddr <= a;
    i_awvalid <= 1'b1;
    i_wdata <= {16'h0000, d};
    i_wstrb <= {2'b00, s};
    i_wvalid <= 1'b1;
    do begin
      @(posedge i_ref_clk);
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
      if (o_bvalid) i_bready <= 1'b1;
    end while (!(o_bvalid && i_bready));
    resp = o_bresp;
    i_bready <= 1'b0;
    m = (a == 8'h10) ? w1 : w2;
    m = {s[1] ? d[15:8] : m[15:8], s[0] ? d[7:0] : m[7:0]};
    if (a == 8'h10) w1 = m;
    if (a == 8'h18) w2 = m;
    cmp(32'(resp), 32'((a == 8'h10 || a == 8'h18) ? RESP_OKAY : RESP_DECERR));
    chk_outs();
  endtask : wr
  task automatic settle(input logic [15:0] t);
    int n;
    n = 0;
    while (o_brightness_level !== t && n < 1000) begin
      @(posedge i_ref_clk);
      n++;
    end
    cmp(32'(o_brightness_level), 32'(t));
    repeat (4) @(posedge i_ref_clk);
  endtask : settle
  task automatic do_reset;
    i_rst <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    w1 = RST_SPREAD_SLOPE_DITHER;
    w2 = RST_DETECT_SHORT_MASK;
    chk_outs();
  endtask : do_reset

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {i_rst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 6'b100000;
    {i_awaddr, i_araddr, i_wdata, i_wstrb} = '0;
    {i_pwm_duty, i_brightness_register_value} = '0;
    i_string_short_raw = 6'h3f;
    do_reset();
    foreach (rows[i]) begin
      i_string_short_raw <= i_string_short_raw ^ 6'h15;
      wr(rows[i].a, rows[i].d, rows[i].s);
    end
    for (int c = 0; c < 8; c++) begin
      wr(8'h10, {11'h000, c[2:0], 2'b00}, 2'h3);
    end
    i_pwm_duty <= 16'h1234;
    settle(16'h1234);
    i_brightness_register_value <= 16'h1244;
    busy = 0;
    wr(8'h10, 16'h0220, 2'h3);
    settle(16'h1244);
    lin = busy;
    cmp(32'(lin >= 16), 32'h1);
    wr(8'h10, 16'h0262, 2'h3);
    busy = 0;
    i_brightness_register_value <= 16'h1234;
    settle(16'h1234);
    cmp(32'(busy > lin), 32'h1);
    axr(8'h40);
    cmp(rd, 32'h0);
    cmp(32'(resp), 32'(RESP_DECERR));
    do_reset();
    conclude();
  end
endmodule : tb_top
